// >>> design/txa_defines.vh
// Constants for the transmit attenuation controller: register offsets,
// field positions, reset values and mode codes.
// Included by bare name from the controller, the checker and the bench; the monitor, limiter and pin model do not include it.
`ifndef TXA_DEFINES_VH
`define TXA_DEFINES_VH

`define TXA_MODE_BYPASS 3'h0
`define TXA_MODE_SET 3'h1
`define TXA_MODE_PIN 3'h3
`define TXA_MODE_CLOSED 3'h4

`define TXA_REG_CTRL 8'h00
`define TXA_REG_TARGET 8'h04
`define TXA_REG_RAMP 8'h08
`define TXA_REG_PIN_STEP 8'h0C
`define TXA_REG_STATUS 8'h10
`define TXA_REG_AVG_THR 8'h14
`define TXA_REG_PEAK_THR 8'h18
`define TXA_REG_MON_CFG 8'h1C
`define TXA_REG_SLEW 8'h20
`define TXA_REG_QUAD 8'h24
`define TXA_REG_LEAK 8'h28
`define TXA_REG_TABLE 8'h2C
`define TXA_REG_SLOT 8'h30

`define TXA_CTRL_TDD_BIT 3
`define TXA_CTRL_MON_EN_BIT 4
`define TXA_CTRL_SLOT_ON_BIT 5
`define TXA_STATUS_ERR_BIT 16

`define TXA_IDX_MAX 10'h347
`define TXA_UNITY_WORD 12'hFFF
`define TXA_QUAD_UNITY 16'h4000

`define TXA_RST_CTRL 32'h00000000
`define TXA_RST_RAMP 32'h00000001
`define TXA_RST_PIN_STEP 32'h00000001
`define TXA_RST_MON_CFG 32'h00010040
`define TXA_RST_SLEW 32'h00000FFF
`define TXA_RST_QUAD 32'h00004000

`endif

// >>> design/txa_power_monitor.v
// Average and peak power monitor for amplifier protection.
// Assumes one power sample per clock and a one-cycle clear pulse from the same domain.
`timescale 1ns/1ps
`default_nettype none
module txa_power_monitor #(
    parameter PW = 16
) (
    input wire clk,
    input wire resetn,
    input wire enable,
    input wire [PW-1:0] power,
    input wire [15:0] integ_len,
    input wire [PW-1:0] avg_thr,
    input wire [PW-1:0] peak_thr,
    input wire [7:0] peak_num,
    input wire clear,
    output reg err_q
);
    reg [31:0] sum_q;
    reg [15:0] cnt_q;
    reg [7:0] peaks_q;
    wire window_end;
    wire is_peak;
    wire [31:0] avg_limit;
    wire avg_over;
    wire peak_over;

    assign window_end = (cnt_q + 16'h0001 >= integ_len);
    assign is_peak = (power > peak_thr);
    assign avg_limit = avg_thr * integ_len;
    // (R9) Average over window
    assign avg_over = window_end && (sum_q + power > avg_limit);
    // (R10) Peak count exceeded
    assign peak_over = ({1'b0, peaks_q} + {8'h00, is_peak}) > {1'b0, peak_num};

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sum_q <= 32'h00000000;
            cnt_q <= 16'h0000;
            peaks_q <= 8'h00;
            err_q <= 1'b0;
        end
        else
        begin
            if (!enable || window_end)
            begin
                sum_q <= 32'h00000000;
                cnt_q <= 16'h0000;
                peaks_q <= 8'h00;
            end
            else
            begin
                sum_q <= sum_q + power;
                cnt_q <= cnt_q + 16'h0001;
                if (is_peak && peaks_q != 8'hFF)
                    peaks_q <= peaks_q + 8'h01;
            end
            // A new event wins over a clear in the same cycle.
            if (enable && (avg_over || peak_over))
                err_q <= 1'b1;
            else if (clear)
                err_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> design/txa_slew_limiter.v
// Slew rate limiter for one sample stream of the transmit datapath.
// Assumes a new sample on every clock and a limit from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module txa_slew_limiter #(
    parameter W = 16
) (
    input wire clk,
    input wire resetn,
    input wire signed [W-1:0] din,
    input wire [W-1:0] limit,
    output reg signed [W-1:0] dout_q
);
    wire signed [W:0] diff;
    wire signed [W:0] lim;
    reg signed [W:0] step;

    // (R15) Output fed back
    assign diff = {din[W-1], din} - {dout_q[W-1], dout_q};
    assign lim = $signed({1'b0, limit});

    // (R13) Clamp per-cycle change
    always @*
    begin
        if (diff > lim)
            step = lim;
        else if (diff < -lim)
            step = -lim;
        else
            step = diff;
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            dout_q <= {W{1'b0}};
        else
            dout_q <= dout_q + step[W-1:0];
    end
endmodule
`default_nettype wire

// >>> design/txa_tx_atten.v
// Transmit attenuation controller with amplifier protection and datapath corrections.
// Assumes a classic Wishbone master on clk, one I/Q sample per clock, and
// increment/decrement pins that are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "txa_defines.vh"
// Notes on behaviour
// (R1) Digital gain word is 12 bits, 0..4095.
// (R2) Analog step word is 6 bits, 0..63.
// (R3) Mode codes: bypass 0, set 1, pin 3, loop 4.
// (R4) Bypass applies zero attenuation; a set error flag overrides it and ramps to maximum.
// (R5) Set mode: slot ramp or constant step.
// (R6) Slot ramp steps between on and off levels.
// (R7) New target starts stepped ramp immediately; the engine first lets any running ramp wait count (wait_q) run down to zero.
// (R8) Two pins raise or lower attenuation by step.
// (R9) Average power over window over threshold flags error.
// (R10) Too many peaks above threshold flags error.
// (R11) Error flag ramps attenuation to maximum.
// (R12) Error flag readable by software.
// (R13) Limiter caps output change per cycle.
// (R14) Ten percent limit gives ten-cycle full ramp.
// (R15) Limiter subtracts fed-back output, clamps difference.
// (R16) Quadrature correction terms applied during transmit.
// (R17) Carrier leakage offset subtracted from samples.
// (R18) Gain is word over 4096, 4095 means unity.
// (R19) Index step is 0.05 dB across both words.
// (R20) Changes saturate at index limits.
module txa_tx_atten #(
    parameter IDX_W = 10,
    parameter TBL_DEPTH = 840
) (
    input wire clk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire pin_inc,
    input wire pin_dec,
    input wire [IDX_W-1:0] closed_loop_index,
    input wire signed [15:0] tx_i_in,
    input wire signed [15:0] tx_q_in,
    output wire signed [15:0] tx_i_out,
    output wire signed [15:0] tx_q_out,
    output reg [11:0] digital_gain_word,
    output reg [5:0] analog_step_word,
    output reg [IDX_W-1:0] atten_index_q,
    output wire amp_error
);
    reg [31:0] ctrl_q, target_q, ramp_q, pin_step_q, avg_thr_q, peak_thr_q;
    reg [31:0] mon_cfg_q, slew_q, quad_q, leak_q, slot_q;
    reg [17:0] tbl [0:TBL_DEPTH-1];
    reg [17:0] entry_q;
    reg [15:0] wait_q;
    reg inc_s1_q, inc_s2_q, inc_s3_q, dec_s1_q, dec_s2_q, dec_s3_q;
    reg err_clear_q;
    reg signed [15:0] corr_i_q, corr_q_q, gain_i_q, gain_q_q;
    reg [15:0] power_q;
    reg [31:0] rd_d;
    reg [IDX_W-1:0] ramp_tgt;
    wire access;
    wire wr;
    wire [2:0] mode;
    wire bypass;
    wire [IDX_W-1:0] max_idx;
    wire signed [31:0] quad_i, quad_x;
    wire signed [31:0] sq_i, sq_q;
    wire [15:0] slew_lim;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (sel[b])
                    merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    // (R20) Saturating step toward a bound
    function [IDX_W-1:0] step_toward;
        input [IDX_W-1:0] cur;
        input [IDX_W-1:0] tgt;
        input [IDX_W-1:0] st;
        begin
            if (tgt > cur)
                step_toward = (tgt - cur > st) ? cur + st : tgt;
            else
                step_toward = (cur - tgt > st) ? cur - st : tgt;
        end
    endfunction

    // (R18) Word over 4096, all-ones is unity
    function signed [15:0] apply_gain;
        input signed [15:0] s;
        input [11:0] word;
        reg signed [28:0] p;
        begin
            p = s * $signed({1'b0, word});
            if (word == `TXA_UNITY_WORD)
                apply_gain = s;
            else
                apply_gain = p[27:12];
        end
    endfunction

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;
    // (R3) Mode selector field
    assign mode = ctrl_q[2:0];
    assign bypass = (mode == `TXA_MODE_BYPASS);
    assign max_idx = `TXA_IDX_MAX;

    // Register writes; the table port writes one entry per access.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= `TXA_RST_CTRL;
            target_q <= 32'h00000000;
            ramp_q <= `TXA_RST_RAMP;
            pin_step_q <= `TXA_RST_PIN_STEP;
            avg_thr_q <= 32'h0000FFFF;
            peak_thr_q <= 32'h0000FFFF;
            mon_cfg_q <= `TXA_RST_MON_CFG;
            slew_q <= `TXA_RST_SLEW;
            quad_q <= `TXA_RST_QUAD;
            leak_q <= 32'h00000000;
            slot_q <= 32'h00000000;
            err_clear_q <= 1'b0;
        end
        else
        begin
            err_clear_q <= wr && wb_adr_i == `TXA_REG_STATUS && wb_sel_i[2] && wb_dat_i[`TXA_STATUS_ERR_BIT];
            if (wr)
            begin
                case (wb_adr_i)
                    `TXA_REG_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_TARGET: target_q <= merge(target_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_RAMP: ramp_q <= merge(ramp_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_PIN_STEP: pin_step_q <= merge(pin_step_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_AVG_THR: avg_thr_q <= merge(avg_thr_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_PEAK_THR: peak_thr_q <= merge(peak_thr_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_MON_CFG: mon_cfg_q <= merge(mon_cfg_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_SLEW: slew_q <= merge(slew_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_QUAD: quad_q <= merge(quad_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_LEAK: leak_q <= merge(leak_q, wb_dat_i, wb_sel_i);
                    `TXA_REG_SLOT: slot_q <= merge(slot_q, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
    end

    // (R19) Index-to-word table, one entry per 0.05 dB
    always @(posedge clk)
    begin
        if (wr && wb_adr_i == `TXA_REG_TABLE && wb_sel_i == 4'hF && wb_dat_i[27:18] < TBL_DEPTH)
            tbl[wb_dat_i[27:18]] <= wb_dat_i[17:0];
    end

    always @*
    begin
        case (wb_adr_i)
            `TXA_REG_CTRL: rd_d = ctrl_q;
            `TXA_REG_TARGET: rd_d = target_q;
            `TXA_REG_RAMP: rd_d = ramp_q;
            `TXA_REG_PIN_STEP: rd_d = pin_step_q;
            // (R12) Error flag and live index
            `TXA_REG_STATUS: rd_d = {15'h0000, amp_error, 6'h00, atten_index_q};
            `TXA_REG_AVG_THR: rd_d = avg_thr_q;
            `TXA_REG_PEAK_THR: rd_d = peak_thr_q;
            `TXA_REG_MON_CFG: rd_d = mon_cfg_q;
            `TXA_REG_SLEW: rd_d = slew_q;
            `TXA_REG_QUAD: rd_d = quad_q;
            `TXA_REG_LEAK: rd_d = leak_q;
            `TXA_REG_SLOT: rd_d = slot_q;
            `TXA_REG_TABLE: rd_d = {8'h00, 2'h0, analog_step_word, digital_gain_word, 4'h0};
            default: rd_d = 32'h00000000;
        endcase
    end

    // Every access, mapped or not, is answered one cycle after it is seen.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= access;
            if (access && !wb_we_i)
                wb_dat_o <= rd_d;
        end
    end

    // Pins pass two flip-flops; the third stage only serves edge detection.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {inc_s1_q, inc_s2_q, inc_s3_q} <= 3'h0;
            {dec_s1_q, dec_s2_q, dec_s3_q} <= 3'h0;
        end
        else
        begin
            {inc_s1_q, inc_s2_q, inc_s3_q} <= {pin_inc, inc_s1_q, inc_s2_q};
            {dec_s1_q, dec_s2_q, dec_s3_q} <= {pin_dec, dec_s1_q, dec_s2_q};
        end
    end

    always @*
    begin
        // (R11) Error drives ramp to maximum
        if (amp_error)
            ramp_tgt = max_idx;
        // (R6) Slot ramp between on and off
        else if (ctrl_q[`TXA_CTRL_TDD_BIT])
            ramp_tgt = ctrl_q[`TXA_CTRL_SLOT_ON_BIT] ? slot_q[IDX_W-1:0] : slot_q[IDX_W+15:16];
        // (R7) Constant step target
        else
            ramp_tgt = target_q[IDX_W-1:0];
        if (ramp_tgt > max_idx)
            ramp_tgt = max_idx;
    end

    // Attenuation index engine.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            atten_index_q <= {IDX_W{1'b0}};
            wait_q <= 16'h0000;
        end
        else if (amp_error || mode == `TXA_MODE_SET)
        begin
            // (R5) Stepped ramp with wait
            if (wait_q != 16'h0000)
                wait_q <= wait_q - 16'h0001;
            else if (atten_index_q != ramp_tgt)
            begin
                atten_index_q <= step_toward(atten_index_q, ramp_tgt, ramp_q[IDX_W-1:0]);
                wait_q <= ramp_q[31:16];
            end
        end
        else if (mode == `TXA_MODE_PIN)
        begin
            wait_q <= 16'h0000;
            // (R8) Increment and decrement pins
            if (inc_s2_q && !inc_s3_q)
                atten_index_q <= step_toward(atten_index_q, max_idx, pin_step_q[IDX_W-1:0]);
            else if (dec_s2_q && !dec_s3_q)
                atten_index_q <= step_toward(atten_index_q, {IDX_W{1'b0}}, pin_step_q[IDX_W-1:0]);
        end
        else if (mode == `TXA_MODE_CLOSED)
        begin
            wait_q <= 16'h0000;
            atten_index_q <= (closed_loop_index > max_idx) ? max_idx : closed_loop_index;
        end
        else
        begin
            wait_q <= 16'h0000;
            atten_index_q <= {IDX_W{1'b0}};
        end
    end

    // Table lookup, then the two control words.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            entry_q <= {6'h00, `TXA_UNITY_WORD};
            digital_gain_word <= `TXA_UNITY_WORD;
            analog_step_word <= 6'h00;
        end
        else
        begin
            if (atten_index_q == {IDX_W{1'b0}})
                entry_q <= {6'h00, `TXA_UNITY_WORD};
            else
                entry_q <= tbl[atten_index_q];
            // (R4) Bypass gives zero attenuation while the error flag is clear
            if (bypass && !amp_error)
            begin
                digital_gain_word <= `TXA_UNITY_WORD;
                analog_step_word <= 6'h00;
            end
            else
            begin
                // (R1) Twelve-bit multiplier word
                digital_gain_word <= entry_q[11:0];
                // (R2) Six-bit step word
                analog_step_word <= entry_q[17:12];
            end
        end
    end

    // (R16) Quadrature gain and phase terms
    assign quad_i = tx_i_in * $signed(quad_q[15:0]);
    assign quad_x = tx_i_in * $signed(quad_q[31:16]);

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            corr_i_q <= 16'h0000;
            corr_q_q <= 16'h0000;
            gain_i_q <= 16'h0000;
            gain_q_q <= 16'h0000;
            power_q <= 16'h0000;
        end
        else
        begin
            // (R17) Leakage offset subtracted
            corr_i_q <= quad_i[29:14] - $signed(leak_q[15:0]);
            corr_q_q <= tx_q_in + quad_x[29:14] - $signed(leak_q[31:16]);
            gain_i_q <= apply_gain(corr_i_q, digital_gain_word);
            gain_q_q <= apply_gain(corr_q_q, digital_gain_word);
            power_q <= sq_i[31:16] + sq_q[31:16];
        end
    end

    // (R14) Fraction of 4096 times 16, so 410 gives ten-cycle ramp
    assign slew_lim = {slew_q[11:0], 4'h0};

    txa_slew_limiter #(.W(16)) u_slew_i (
        .clk(clk),
        .resetn(resetn),
        .din(gain_i_q),
        .limit(slew_lim),
        .dout_q(tx_i_out)
    );

    txa_slew_limiter #(.W(16)) u_slew_q (
        .clk(clk),
        .resetn(resetn),
        .din(gain_q_q),
        .limit(slew_lim),
        .dout_q(tx_q_out)
    );

    assign sq_i = tx_i_out * tx_i_out;
    assign sq_q = tx_q_out * tx_q_out;

    txa_power_monitor #(.PW(16)) u_mon (
        .clk(clk),
        .resetn(resetn),
        .enable(ctrl_q[`TXA_CTRL_MON_EN_BIT]),
        .power(power_q),
        .integ_len(mon_cfg_q[15:0]),
        .avg_thr(avg_thr_q[15:0]),
        .peak_thr(peak_thr_q[15:0]),
        .peak_num(mon_cfg_q[23:16]),
        .clear(err_clear_q),
        .err_q(amp_error)
    );
endmodule
`default_nettype wire

// >>> testbench/txa_bb_pins.sv
// Baseband side of the increment and decrement pins.
// Assumes pulses are requested one at a time by the bench.
`timescale 1ns/1ps
`default_nettype none
module txa_bb_pins (
    input wire logic clk,
    output logic pin_inc,
    output logic pin_dec
);
    initial
    begin
        pin_inc = 1'b0;
        pin_dec = 1'b0;
    end
    task pulse(input logic up, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (up)
                pin_inc <= 1'b1;
            else
                pin_dec <= 1'b1;
            repeat (4) @(posedge clk);
            pin_inc <= 1'b0;
            pin_dec <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/txa_tx_atten_properties.sv
// Port-level checker for the transmit attenuation controller.
// Assumes the bind below attaches it to every controller instance.
`timescale 1ns/1ps
`default_nettype none
`include "txa_defines.vh"
module txa_tx_atten_properties #(
    parameter IDX_W = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [11:0] digital_gain_word,
    input wire logic [5:0] analog_step_word,
    input wire logic [IDX_W-1:0] atten_index_q,
    input wire logic amp_error
);
    logic take;
    logic rd;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = take && !wb_we_i;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_holds_idle: assert property (!rd |=> $stable(wb_dat_o))
        else $error("read data changed without read");
    a_unmapped_reads_zero: assert property (rd && wb_adr_i == 8'h3C |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_status_shows_flag: assert property (rd && wb_adr_i == `TXA_REG_STATUS |=>
        wb_dat_o[16] == $past(amp_error) && wb_dat_o[9:0] == $past(atten_index_q))
        else $error("status read wrong");
    a_index_saturates: assert property (atten_index_q <= `TXA_IDX_MAX)
        else $error("index above maximum");
    a_zero_index_unity: assert property ($past(atten_index_q, 2) == 0 |->
        digital_gain_word == 12'hFFF && analog_step_word == 6'h00)
        else $error("index zero words wrong");
    a_error_ramps_up: assert property ($past(amp_error) && amp_error |->
        atten_index_q >= $past(atten_index_q))
        else $error("index fell while error set");
    a_error_clear_cause: assert property ($fell(amp_error) |->
        $past(wb_ack_o && wb_we_i && wb_adr_i == `TXA_REG_STATUS && wb_dat_i[16]))
        else $error("error flag cleared without write");
    c_error_seen: cover property ($rose(amp_error));
    c_index_max: cover property (atten_index_q == `TXA_IDX_MAX);
    c_status_read: cover property (rd && wb_adr_i == `TXA_REG_STATUS);
endmodule
bind txa_tx_atten txa_tx_atten_properties #(.IDX_W(IDX_W)) i_txa_tx_atten_properties (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .digital_gain_word(digital_gain_word),
    .analog_step_word(analog_step_word), .atten_index_q(atten_index_q), .amp_error(amp_error)
);
`default_nettype wire

// >>> testbench/txa_tx_atten_tb.sv
// Self-checking bench for the transmit attenuation controller.
// Assumes a Wishbone ack one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
`include "txa_defines.vh"
module txa_tx_atten_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [9:0] cl_idx = 10'h000;
    logic signed [15:0] tx_i_in = 16'sh0000;
    logic signed [15:0] tx_q_in = 16'sh0000;
    logic signed [15:0] prev;
    logic signed [16:0] d;
    logic [31:0] rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, pin_inc, pin_dec, amp_error;
    wire signed [15:0] tx_i_out, tx_q_out;
    wire [11:0] digital_gain_word;
    wire [5:0] analog_step_word;
    wire [9:0] atten_index_q;
    int err_total = 0;
    int cmp_count = 0;
    int n, chg, dmax;
    logic [7:0] ra [10] = '{`TXA_REG_CTRL, `TXA_REG_RAMP, `TXA_REG_PIN_STEP, `TXA_REG_MON_CFG,
        `TXA_REG_SLEW, `TXA_REG_QUAD, `TXA_REG_AVG_THR, `TXA_REG_PEAK_THR, `TXA_REG_STATUS, 8'h3C};
    logic [31:0] rv [10] = '{`TXA_RST_CTRL, `TXA_RST_RAMP, `TXA_RST_PIN_STEP, `TXA_RST_MON_CFG,
        `TXA_RST_SLEW, `TXA_RST_QUAD, 32'h0000FFFF, 32'h0000FFFF, 32'h00000000, 32'h00000000};

    txa_tx_atten i_txa_tx_atten (
        .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_inc(pin_inc), .pin_dec(pin_dec), .closed_loop_index(cl_idx),
        .tx_i_in(tx_i_in), .tx_q_in(tx_q_in), .tx_i_out(tx_i_out), .tx_q_out(tx_q_out),
        .digital_gain_word(digital_gain_word), .analog_step_word(analog_step_word),
        .atten_index_q(atten_index_q), .amp_error(amp_error)
    );
    txa_bb_pins i_txa_bb_pins (.clk(clk), .pin_inc(pin_inc), .pin_dec(pin_dec));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dw;
        do
        begin
            @(posedge clk);
        end
        while (wb_ack_o !== 1'b1);
        dr = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] dw);
        wb_cycle(1'b1, a, dw, rd);
    endtask

    // Waits for the index (w 0) or the error flag (w 1) to reach v, then compares.
    task wait_sig(input int w, input logic [31:0] v);
        n = 0;
        while ((w == 0 ? {22'h0, atten_index_q} : {31'h0, amp_error}) !== v && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        check(w == 0 ? {22'h0, atten_index_q} : {31'h0, amp_error}, v);
    endtask

    task drive(input logic signed [15:0] i, input logic signed [15:0] q, input int cyc);
        @(posedge clk);
        tx_i_in <= i;
        tx_q_in <= q;
        repeat (cyc) @(posedge clk);
    endtask

    task test_done;
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #300000;
        err_total++;
        test_done;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            wb_cycle(1'b0, ra[k], 32'h0, rd);
            check(rd, rv[k]);
        end
        // Unity words in every entry keep the sample path free of unknowns.
        for (int t = 0; t < 840; t++)
            wr(`TXA_REG_TABLE, {4'h0, 10'(t), 18'h00FFF});
        wr(`TXA_REG_TABLE, 32'h000C1FFA);
        wr(`TXA_REG_RAMP, 32'h00100001);
        wr(`TXA_REG_TARGET, 32'h00000003);
        wr(`TXA_REG_CTRL, {29'h0, `TXA_MODE_SET});
        wait_sig(0, 32'h3);
        check(n >= 32, 1'b1);
        repeat (3) @(posedge clk);
        check({14'h0, analog_step_word, digital_gain_word}, 32'h00001FFA);
        wr(`TXA_REG_RAMP, 32'h00000064);
        wr(`TXA_REG_TARGET, 32'h000003FF);
        wait_sig(0, `TXA_IDX_MAX);
        wr(`TXA_REG_SLOT, 32'h00140032);
        wr(`TXA_REG_CTRL, 32'h00000029);
        wait_sig(0, 32'h32);
        wr(`TXA_REG_CTRL, 32'h00000009);
        wait_sig(0, 32'h14);
        cl_idx <= 10'h005;
        wr(`TXA_REG_CTRL, {29'h0, `TXA_MODE_CLOSED});
        wait_sig(0, 32'h5);
        cl_idx <= 10'h3E8;
        wait_sig(0, `TXA_IDX_MAX);
        wr(`TXA_REG_CTRL, {29'h0, `TXA_MODE_BYPASS});
        wait_sig(0, 32'h0);
        repeat (3) @(posedge clk);
        check({14'h0, analog_step_word, digital_gain_word}, 32'h00000FFF);
        wr(`TXA_REG_LEAK, 32'h00200010);
        drive(16'sd1000, -16'sd500, 12);
        check({16'h0, tx_i_out}, 32'h000003D8);
        check({16'h0, tx_q_out}, 32'h0000FDEC);
        wr(`TXA_REG_LEAK, 32'h00000000);
        wr(`TXA_REG_SLEW, 32'd410);
        drive(16'sh8000, 16'sd0, 12);
        drive(16'sd32767, 16'sd0, 0);
        chg = 0;
        dmax = 0;
        prev = tx_i_out;
        repeat (24)
        begin
            @(posedge clk);
            d = tx_i_out - prev;
            if (d != 0)
                chg++;
            if (d > dmax)
                dmax = d;
            prev = tx_i_out;
        end
        check(chg, 10);
        check(dmax <= 6560, 1'b1);
        check({16'h0, tx_i_out}, 32'h00007FFF);
        wr(`TXA_REG_SLEW, `TXA_RST_SLEW);
        drive(16'sd0, 16'sd0, 8);
        wr(`TXA_REG_PIN_STEP, 32'h00000002);
        wr(`TXA_REG_CTRL, {29'h0, `TXA_MODE_PIN});
        i_txa_bb_pins.pulse(1'b1, 3);
        wait_sig(0, 32'h6);
        i_txa_bb_pins.pulse(1'b0, 4);
        wait_sig(0, 32'h0);
        wr(`TXA_REG_AVG_THR, 32'h00000010);
        wr(`TXA_REG_MON_CFG, 32'h00FF0040);
        wr(`TXA_REG_CTRL, 32'h00000010);
        drive(16'sh7000, 16'sh7000, 0);
        wait_sig(1, 32'h1);
        wait_sig(0, `TXA_IDX_MAX);
        wb_cycle(1'b0, `TXA_REG_STATUS, 32'h0, rd);
        check(rd, 32'h00010347);
        drive(16'sd0, 16'sd0, 200);
        wr(`TXA_REG_STATUS, 32'h00010000);
        wb_cycle(1'b0, `TXA_REG_STATUS, 32'h0, rd);
        check(rd[16], 1'b0);
        wait_sig(0, 32'h0);
        wr(`TXA_REG_AVG_THR, 32'h0000FFFF);
        wr(`TXA_REG_PEAK_THR, 32'h00000100);
        wr(`TXA_REG_MON_CFG, 32'h00020040);
        drive(16'sh7000, 16'sh7000, 1);
        drive(16'sd0, 16'sd0, 150);
        check(amp_error, 1'b0);
        drive(16'sh7000, 16'sh7000, 8);
        drive(16'sd0, 16'sd0, 0);
        wait_sig(1, 32'h1);
        test_done;
    end
endmodule
`default_nettype wire
